// ### verilog/haptic_drive.sv
// Haptic drive level generation, protection and thermal monitoring.
module haptic_drive
    import haptic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Configuration
    input wire logic [1:0] load_type_select,
    input wire logic drive_source_select,
    input wire logic signed [7:0] amplitude_setting,
    input wire logic amplitude_range_select,
    input wire logic [6:0] dead_zone_range,
    input wire logic [2:0] output_gain,
    input wire logic [2:0] slew_bandwidth,
    input wire logic thermal_always_on,
    // Host level input pin
    input wire logic level_input,
    // Analog and system status
    input wire logic motor_overcurrent,
    input wire logic touch_active,
    input wire logic prox_active,
    input wire logic adc_busy,
    // Temperature sensor
    output logic temp_measure_req,
    input wire logic temp_done,
    input wire logic [7:0] temp_code,
    // Motor converter and outputs
    output logic signed [7:0] dac_code,
    output logic motor_outputs_grounded,
    // Status
    output logic short_circuit_flag,
    output logic thermal_warning_flag,
    output logic thermal_alarm_flag,
    output logic chip_shutdown,
    output logic discard_results
);
    typedef enum logic [1:0] {T_IDLE, T_PENDING, T_MEASURE} therm_state_e;

    duty_if dif ();
    duty_meter u_meter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .dif(dif)
    );
    assign dif.level = level_input;

    // Slow oscillator tick from the reference clock.
    logic [8:0] div_q;
    logic slow_tick;
    assign slow_tick = (div_q == SLOW_TICK_LAST);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_q <= 9'h0;
        end else begin
            div_q <= slow_tick ? 9'h0 : div_q + 9'h1;
        end
    end

    // Drive code source and sampling rate.
    logic is_erm, is_lra, drive_on, sample_now;
    logic signed [7:0] drive_code_q;
    assign is_erm = (load_type_select == LOAD_ERM);
    assign is_lra = (load_type_select == LOAD_LRA);
    // Range bit is the host's to set; it only scales the analog stage.
    logic unused_range;
    assign unused_range = amplitude_range_select;
    // Register mode on the mass load ignores the pin entirely.
    assign sample_now = drive_source_select ? (is_erm ? slow_tick : dif.rise) : dif.rise;
    assign drive_on = (load_type_select != LOAD_OFF) && !short_circuit_flag && !thermal_alarm_flag;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            drive_code_q <= 8'sh00;
        end else if (sample_now) begin
            drive_code_q <= drive_source_select ? amplitude_setting : dif.code;
        end
    end

    // Dead-zone hold: counted per input period, slow tick or carrier period.
    logic [7:0] code_mag;
    logic in_dz, dz_step, squelch;
    logic [9:0] dz_cnt_q;
    assign code_mag = drive_code_q[7] ? 8'(-drive_code_q) : drive_code_q;
    assign in_dz = code_mag <= {1'b0, dead_zone_range};
    assign dz_step = is_lra ? dif.rise : sample_now;
    assign squelch = dz_cnt_q > DZ_LIMIT;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dz_cnt_q <= 10'h0;
        end else if (!in_dz) begin
            dz_cnt_q <= 10'h0;
        end else if (dz_step && !squelch) begin
            dz_cnt_q <= dz_cnt_q + 10'h1;
        end
    end

    // Gain scaling with saturation to the converter range.
    logic signed [11:0] product, scaled;
    logic signed [7:0] target;
    assign product = drive_code_q * $signed({1'b0, output_gain});
    assign scaled = product >>> GAIN_SHIFT;
    assign target = squelch ? 8'sh00 :
                    (scaled > 12'sh07F) ? CODE_MAX :
                    (scaled < -12'sh07F) ? -CODE_MAX : scaled[7:0];

    // First-order low-pass, so a step in code reaches the motor over several slow ticks unless slew_bandwidth is 0.
    logic signed [15:0] acc_q;
    logic signed [16:0] diff, step, sum;
    assign diff = $signed({target, 8'h00}) - acc_q;
    assign step = diff >>> slew_bandwidth;
    assign sum = acc_q + step;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= 16'sh0000;
        end else if (!drive_on) begin
            acc_q <= 16'sh0000;
        end else if (slow_tick) begin
            acc_q <= sum[15:0];
        end
    end

    // Envelope on a carrier for the resonant load, plain level otherwise.
    logic signed [7:0] env, dac_d;
    assign env = acc_q[15:8];
    assign dac_d = !drive_on ? 8'sh00 :
                   is_lra ? (dif.carrier_pos ? env : 8'(-env)) :
                   env;
    logic short_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dac_code <= 8'sh00;
            motor_outputs_grounded <= 1'b1;
            short_q <= 1'b0;
        end else begin
            dac_code <= dac_d;
            motor_outputs_grounded <= !drive_on;
            short_q <= motor_overcurrent;
        end
    end
    assign short_circuit_flag = short_q;

    // Thermal measurement scheduling.
    therm_state_e tstate_q, tstate_d;
    logic [9:0] tcnt_q;
    logic meas_due, chip_active, go;
    logic warn_q, alarm_q, discard_q, req_q;
    assign meas_due = slow_tick && (tcnt_q == TEMP_INTERVAL_LAST);
    assign chip_active = (load_type_select != LOAD_OFF) || touch_active || prox_active;
    always_comb begin
        tstate_d = tstate_q;
        go = 1'b0;
        case (tstate_q)
            T_IDLE: begin
                if (meas_due && thermal_always_on) begin
                    tstate_d = T_MEASURE;
                    go = 1'b1;
                end else if (meas_due && chip_active) begin
                    tstate_d = adc_busy ? T_PENDING : T_MEASURE;
                    go = !adc_busy;
                end
            end
            T_PENDING: begin
                if (thermal_always_on || !adc_busy) begin
                    tstate_d = T_MEASURE;
                    go = 1'b1;
                end else if (!chip_active) begin
                    tstate_d = T_IDLE;
                end
            end
            T_MEASURE: begin
                if (temp_done) begin
                    tstate_d = T_IDLE;
                end
            end
            default: tstate_d = T_IDLE;
        endcase
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tstate_q <= T_IDLE;
            tcnt_q <= 10'h0;
            req_q <= 1'b0;
        end else begin
            tstate_q <= tstate_d;
            req_q <= go;
            if (slow_tick) begin
                tcnt_q <= tcnt_q + 10'h1;
            end
        end
    end
    assign temp_measure_req = req_q;

    // Flags follow each finished measurement.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            warn_q <= 1'b0;
            alarm_q <= 1'b0;
            discard_q <= 1'b0;
        end else begin
            discard_q <= 1'b0;
            if (temp_done && tstate_q == T_MEASURE) begin
                warn_q <= temp_code > TEMP_WARN_C;
                alarm_q <= temp_code > TEMP_ALARM_C;
                discard_q <= alarm_q && !(temp_code > TEMP_ALARM_C);
            end
        end
    end
    assign thermal_warning_flag = warn_q;
    assign thermal_alarm_flag = alarm_q;
    assign chip_shutdown = alarm_q;
    assign discard_results = discard_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_type_off_quiet: assert property ((load_type_select == LOAD_OFF) |=>
        (dac_code == 8'sh00) && motor_outputs_grounded)
        else $error("Driver active with load type zero.");
    a_short_grounds: assert property (motor_overcurrent |=> short_circuit_flag ##1 motor_outputs_grounded)
        else $error("Overcurrent did not ground the outputs.");
    a_short_resume: assert property ($fell(short_circuit_flag) && !thermal_alarm_flag
        && load_type_select != LOAD_OFF |=> !motor_outputs_grounded)
        else $error("Drive did not resume after short cleared.");
    // The flag may drop on the very next result, so shutdown is checked in the cycle of the alarm itself.
    a_alarm_shuts: assert property (thermal_alarm_flag |-> chip_shutdown ##1 motor_outputs_grounded)
        else $error("Alarm did not shut down drive.");
    a_short_release: assert property (!motor_overcurrent |=> !short_circuit_flag)
        else $error("Short flag stayed set after overcurrent ended.");
    a_pin_source: assert property (!drive_source_select && dif.rise |=> drive_code_q == $past(dif.code))
        else $error("Pin mode code not taken from duty meter.");
    a_reg_mass: assert property (drive_source_select && is_erm && slow_tick |=>
        drive_code_q == $past(amplitude_setting))
        else $error("Register code not sampled on slow tick.");
    a_reg_hold: assert property (drive_source_select && is_erm && !slow_tick |=> $stable(drive_code_q))
        else $error("Register code changed between slow ticks.");
    a_reg_reso: assert property (drive_source_select && is_lra && dif.rise |=>
        drive_code_q == $past(amplitude_setting))
        else $error("Resonant register code not sampled at pin rate.");
    // With no slew limit one slow tick reaches zero, so the squelch check is exact there.
    a_squelch_zero: assert property (squelch && !is_lra && drive_on && slow_tick && slew_bandwidth == 3'h0
        |=> env == 8'sh00 ##1 dac_code == 8'sh00)
        else $error("Squelched mass load still driven.");
    a_dz_clear: assert property (!in_dz |=> dz_cnt_q == 10'h0)
        else $error("Dead-zone count kept outside the dead zone.");
    a_filter_hold: assert property (drive_on && !slow_tick |=> $stable(acc_q))
        else $error("Filter moved between slow ticks.");
    a_mass_level: assert property (!is_lra && drive_on |=> dac_code == $past(env))
        else $error("Level drive does not follow the envelope.");
    a_reso_pos: assert property (is_lra && drive_on && dif.carrier_pos |=> dac_code == $past(env))
        else $error("Carrier positive half wrong.");
    a_reso_neg: assert property (is_lra && drive_on && !dif.carrier_pos |=> dac_code == -$past(env))
        else $error("Carrier negative half wrong.");
    a_meter_pulse: assert property (dif.rise |=> !dif.rise)
        else $error("Rise pulse longer than one cycle.");
    a_squelch_count: assert property ($rose(squelch) |-> $past(in_dz) && $past(dz_cnt_q) == DZ_LIMIT)
        else $error("Squelch rose without full dead-zone count.");
    a_temp_defer: assert property (!thermal_always_on && adc_busy |=> !temp_measure_req)
        else $error("Measurement started during conversion.");
    a_temp_always: assert property (thermal_always_on && meas_due && tstate_q == T_IDLE |=> temp_measure_req)
        else $error("Always-on measurement not started.");
    a_alarm_set: assert property (temp_done && tstate_q == T_MEASURE && temp_code > TEMP_ALARM_C
        |=> thermal_alarm_flag && thermal_warning_flag)
        else $error("Alarm flag not set above threshold.");
    a_discard_pulse: assert property ($fell(thermal_alarm_flag) |-> discard_results ##1 !discard_results)
        else $error("Results not discarded after shutdown.");
    // A measurement interval outlasts a short run, so these mostly guard long system runs.
    a_warn_set: assert property (temp_done && tstate_q == T_MEASURE
        |=> thermal_warning_flag == ($past(temp_code) > TEMP_WARN_C))
        else $error("Warning flag does not match the last result.");
    a_req_pulse: assert property (temp_measure_req |=> !temp_measure_req)
        else $error("Measurement request longer than one cycle.");
    a_idle_no_temp: assert property (!thermal_always_on && !chip_active && tstate_q == T_IDLE
        |=> !temp_measure_req)
        else $error("Measurement started while idle.");

    c_mass_drive: cover property (is_erm && drive_on && dac_code != 8'sh00);
    c_reso_flip: cover property (is_lra && drive_on && $changed(dif.carrier_pos));
    c_squelch: cover property ($rose(squelch));
    c_alarm_cycle: cover property ($fell(thermal_alarm_flag));
    c_short_cycle: cover property ($fell(short_circuit_flag));
endmodule

// ### verilog/haptic_pkg.sv
// Shared constants for the haptic drive controller.
package haptic_pkg;
    // Load type select encodings.
    localparam logic [1:0] LOAD_OFF = 2'h0;
    localparam logic [1:0] LOAD_LRA = 2'h1;
    localparam logic [1:0] LOAD_ERM = 2'h2;
    // Clock and slow oscillator timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLOW_OSC_PERIOD_NS = 31250;
    localparam int SLOW_TICK_CYCLES = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [8:0] SLOW_TICK_LAST = 9'(SLOW_TICK_CYCLES - 1);
    // Dead-zone hold count and temperature measurement interval.
    localparam logic [9:0] DZ_LIMIT = 10'h200;
    localparam logic [9:0] TEMP_INTERVAL_LAST = 10'h3FF;
    // Thresholds in degrees Celsius; the sensor code is degrees Celsius.
    localparam logic [7:0] TEMP_WARN_C = 8'd120;
    localparam logic [7:0] TEMP_ALARM_C = 8'd155;
    // Duty cycle to drive code scale: full period maps to 254 steps.
    localparam logic [7:0] DUTY_STEPS = 8'hFE;
    localparam logic signed [8:0] CODE_MID = 9'sh07F;
    localparam logic signed [7:0] CODE_MAX = 8'sh7F;
    // Gain of 4 is unity; the shift removes it.
    localparam int GAIN_SHIFT = 2;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
endpackage

// ### verilog/duty_if.sv
// Signals between the duty cycle meter and the drive controller.
interface duty_if;
    logic level;
    logic rise;
    logic signed [7:0] code;
    logic carrier_pos;
    modport meter (input level, output rise, output code, output carrier_pos);
    modport user (output level, input rise, input code, input carrier_pos);
endinterface

// ### verilog/duty_meter.sv
// Measures the level input duty cycle and derives the carrier phase.
module duty_meter
    import haptic_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Measurement results
    duty_if.meter dif
);
    logic prev_q;
    logic [15:0] cnt_q, high_q, period_q;
    logic rise_q;
    logic signed [7:0] code_q;
    logic edge_seen;
    logic [15:0] cnt_next, high_next, period_now;
    logic [23:0] scaled;
    logic [23:0] quot;
    logic signed [8:0] code_wide;

    assign edge_seen = dif.level & ~prev_q;
    assign cnt_next = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 16'h1;
    assign high_next = (high_q == CNT_MAX || !dif.level) ? high_q : high_q + 16'h1;
    // High time against full period between rising edges.
    assign period_now = cnt_next;
    assign scaled = high_q * DUTY_STEPS;
    assign quot = (period_now == 16'h0) ? 24'h0 : scaled / {8'h0, period_now};
    // Half duty gives zero, one step per 1/254 of the period.
    assign code_wide = $signed({1'b0, quot[7:0]}) - CODE_MID;
    assign dif.rise = rise_q;
    assign dif.code = code_q;
    assign dif.carrier_pos = cnt_q < {1'b0, period_q[15:1]};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
            cnt_q <= 16'h0;
            high_q <= 16'h0;
            period_q <= 16'h0;
            rise_q <= 1'b0;
            code_q <= 8'sh00;
        end else begin
            prev_q <= dif.level;
            rise_q <= edge_seen;
            if (edge_seen) begin
                cnt_q <= 16'h0;
                high_q <= 16'h1;
                period_q <= period_now;
                code_q <= (code_wide > 9'sh07F) ? CODE_MAX : code_wide[7:0];
            end else begin
                cnt_q <= cnt_next;
                high_q <= high_next;
            end
        end
    end
endmodule

// ### tb/pwm_host.sv
// Host model that drives the pulse-width level input pin.
module pwm_host (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Waveform setting
    input wire logic [7:0] period,
    input wire logic [7:0] high_len,
    input wire logic hold_low,
    // Level pin
    output logic level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    assign cnt_d = (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
            level <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            // A register-driven mass load wants the pin grounded, not left toggling.
            level <= !hold_low && (cnt_q < high_len);
        end
    end
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the haptic drive controller.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import haptic_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] load_sel = 2'h0;
    logic src_sel = 1'b0;
    logic signed [7:0] amp = 8'h00;
    logic range_sel = 1'b0;
    logic [6:0] dz = 7'h00;
    logic [2:0] gain = 3'h4;
    logic [2:0] bw = 3'h0;
    logic always_on = 1'b1;
    logic overcur = 1'b0;
    logic idle_in = 1'b0;
    logic temp_done = 1'b0;
    logic [7:0] temp_code = 8'h00;
    logic [7:0] period = 8'h14;
    logic [7:0] high_len = 8'h0A;
    logic hold_low = 1'b0;
    logic level, req, grounded, short_f, warn_f, alarm_f, shut, discard;
    logic signed [7:0] dac;
    int err_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'h00f2;
    int i, e, mx, mn;

    always #50 ref_clk = ~ref_clk;

    pwm_host u_host (.ref_clk(ref_clk), .resetn(resetn), .period(period), .high_len(high_len),
        .hold_low(hold_low), .level(level));

    haptic_drive u_dut (.ref_clk(ref_clk), .resetn(resetn), .load_type_select(load_sel),
        .drive_source_select(src_sel), .amplitude_setting(amp), .amplitude_range_select(range_sel),
        .dead_zone_range(dz), .output_gain(gain), .slew_bandwidth(bw), .thermal_always_on(always_on),
        .level_input(level), .motor_overcurrent(overcur), .touch_active(idle_in), .prox_active(idle_in),
        .adc_busy(idle_in), .temp_measure_req(req), .temp_done(temp_done), .temp_code(temp_code),
        .dac_code(dac), .motor_outputs_grounded(grounded), .short_circuit_flag(short_f),
        .thermal_warning_flag(warn_f), .thermal_alarm_flag(alarm_f), .chip_shutdown(shut),
        .discard_results(discard));

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    function automatic logic [7:0] scaled(input int code, input int g);
        int v;
        v = (code * g) >>> 2;
        if (v > 127) v = 127;
        if (v < -127) v = -127;
        return v[7:0];
    endfunction

    function automatic int duty(input int h, input int p);
        return (h * 254) / p - 127;
    endfunction

    // The run is about 26k cycles; the ceiling leaves ample margin.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            close_out();
        end
    end

    // Temperature intervals span over 300k cycles, so periodic measurement is beyond
    // this run; only the refusal of an unrequested result is exercised.
    initial begin
        repeat (3) @(posedge ref_clk);
        check("dac_rst", dac, 8'h00);
        check("gnd_rst", grounded, 8'h01);
        resetn <= 1'b1;
        cyc(700);
        check("dac_off", dac, 8'h00);
        @(posedge ref_clk);
        load_sel <= LOAD_ERM;
        src_sel <= 1'b1;
        range_sel <= 1'b1;
        hold_low <= 1'b1;
        dz <= 7'h05;
        for (i = 0; i < 6; i++) begin
            e = (i == 0) ? 127 : (i == 1) ? -127 : 6 + ($unsigned($random(seed)) % 122);
            if (i > 1 && $random(seed) % 2 == 0) e = -e;
            @(posedge ref_clk);
            amp <= e[7:0];
            gain <= (i < 2) ? 3'h7 : 3'($random(seed));
            cyc(700);
            check("dac_erm_reg", dac, scaled(e, gain));
        end
        @(posedge ref_clk);
        overcur <= 1'b1;
        cyc(1);
        check("short_flag", short_f, 8'h01);
        cyc(2);
        check("gnd_short", grounded, 8'h01);
        check("dac_short", dac, 8'h00);
        @(posedge ref_clk);
        overcur <= 1'b0;
        cyc(700);
        check("short_clear", short_f, 8'h00);
        check("dac_resume", dac, scaled(e, gain));
        @(posedge ref_clk);
        temp_code <= 8'hA0;
        temp_done <= 1'b1;
        @(posedge ref_clk);
        temp_done <= 1'b0;
        cyc(2);
        check("alarm_stray", alarm_f, 8'h00);
        check("shut_stray", shut, 8'h00);
        check("warn_stray", warn_f, 8'h00);
        check("discard_stray", discard, 8'h00);
        check("req_idle", req, 8'h00);
        @(posedge ref_clk);
        src_sel <= 1'b0;
        hold_low <= 1'b0;
        dz <= 7'h00;
        gain <= 3'h4;
        for (i = 0; i < 6; i++) begin
            e = (i == 0) ? 1 : (i == 1) ? 19 : 1 + ($unsigned($random(seed)) % 19);
            @(posedge ref_clk);
            high_len <= e[7:0];
            cyc(1000);
            check("dac_erm_pin", dac, scaled(duty(e, 20), 4));
        end
        @(posedge ref_clk);
        dz <= 7'h0F;
        high_len <= 8'h0B;
        cyc(1000);
        check("dac_dz_early", dac, scaled(duty(11, 20), 4));
        cyc(10700);
        check("dac_dz_squelch", dac, 8'h00);
        for (i = 0; i < 2; i++) begin
            @(posedge ref_clk);
            load_sel <= LOAD_LRA;
            src_sel <= i[0];
            dz <= 7'h00;
            high_len <= 8'h11;
            amp <= 8'hC4;
            cyc(1000);
            e = i ? 60 : duty(17, 20);
            mx = -200;
            mn = 200;
            repeat (60) begin
                @(negedge ref_clk);
                if (dac > mx) mx = dac;
                if (dac < mn) mn = dac;
            end
            check("lra_pos", mx[7:0], scaled(e, 4));
            check("lra_neg", mn[7:0], scaled(-e, 4));
        end
        @(posedge ref_clk);
        load_sel <= LOAD_OFF;
        cyc(700);
        check("dac_off_end", dac, 8'h00);
        close_out();
    end
endmodule
